// File: core/gap_bank_pkg.sv
// Package: command codes, field layouts, reset values and widths of the deadtime and rail order bank
package gap_bank_pkg;
    // Command codes on the management bus
    localparam logic [7:0] CMD_EXT_TEMP_CAL_OFFSET = 8'hDA;
    localparam logic [7:0] CMD_STRAPPED_VOUT_CEILING = 8'hDB;
    localparam logic [7:0] CMD_SENSE_TEMP_CORRECTION = 8'hDC;
    localparam logic [7:0] CMD_SWITCH_GAP_VALUES = 8'hDD;
    localparam logic [7:0] CMD_SWITCH_GAP_MODE_LIMITS = 8'hDE;
    localparam logic [7:0] CMD_RAIL_ORDER_LINKS = 8'hE0;

    // Field positions
    localparam int GAP_HL_LSB = 8;
    localparam int GAP_LH_LSB = 0;
    localparam int GAP_W = 8;
    localparam int MIN_HL_LSB = 8;
    localparam int MIN_LH_LSB = 0;
    localparam int MIN_W = 7;
    localparam int FREEZE_HL_BIT = 15;
    localparam int FREEZE_LH_BIT = 7;
    localparam int PRE_ID_LSB = 8;
    localparam int POST_ID_LSB = 0;
    localparam int ID_W = 5;
    localparam int PRE_EN_BIT = 15;
    localparam int POST_EN_BIT = 7;

    // Writable bit masks; unassigned bits read zero
    localparam logic [15:0] MODE_LIMITS_MASK = 16'hFFFF;
    localparam logic [15:0] ORDER_LINKS_MASK = 16'h9F9F;
    localparam logic [15:0] BYTE_MASK = 16'h00FF;

    // Reset values
    localparam logic [15:0] EXT_TEMP_CAL_OFFSET_RST = 16'h0000;
    localparam logic [7:0] SENSE_TEMP_CORRECTION_RST = 8'h00;
    localparam logic [15:0] SWITCH_GAP_VALUES_RST = 16'h0000;
    localparam logic [15:0] SWITCH_GAP_MODE_LIMITS_RST = 16'h0000;
    localparam logic [15:0] RAIL_ORDER_LINKS_RST = 16'h0000;
    // Adaptive ceiling after reset, in ns
    localparam logic signed [7:0] GAP_MAX_RST_NS = 8'sh3C;
    // Step of the minimum limit fields, in ns
    localparam int MIN_STEP_NS = 2;
    // Internal signed width for deadtime arithmetic, in ns
    localparam int NS_W = 10;

    typedef logic signed [NS_W-1:0] ns_t;
endpackage : gap_bank_pkg

// File: core/gap_cfg_if.sv
// Interface: stored deadtime settings toward the deadtime selector and its chosen values back
`timescale 1ns/100ps
`default_nettype none
interface gap_cfg_if;
    logic signed [7:0] gap_hl;
    logic signed [7:0] gap_lh;
    logic signed [7:0] max_hl;
    logic signed [7:0] max_lh;
    logic signed [6:0] min_hl;
    logic signed [6:0] min_lh;
    logic freeze_hl;
    logic freeze_lh;
    logic signed [7:0] eff_hl;
    logic signed [7:0] eff_lh;

    modport bank (output gap_hl, gap_lh, max_hl, max_lh, min_hl, min_lh, freeze_hl, freeze_lh,
                  input eff_hl, eff_lh);
    modport sel (input gap_hl, gap_lh, max_hl, max_lh, min_hl, min_lh, freeze_hl, freeze_lh,
                 output eff_hl, eff_lh);
endinterface : gap_cfg_if
`default_nettype wire

// File: core/gap_select.sv
// Deadtime selector: clamps adaptive proposals per edge, or applies the stored value when frozen
`timescale 1ns/100ps
`default_nettype none
module gap_select
    import gap_bank_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic signed [7:0] adapt_hl_in,
    input wire logic signed [7:0] adapt_lh_in,
    gap_cfg_if.sel cfg
);
    logic signed [7:0] adapt [2];
    logic signed [7:0] stored [2];
    logic signed [7:0] maxv [2];
    logic signed [6:0] minv [2];
    logic frz [2];

    assign adapt[0] = adapt_hl_in;
    assign adapt[1] = adapt_lh_in;
    assign stored[0] = cfg.gap_hl;
    assign stored[1] = cfg.gap_lh;
    assign maxv[0] = cfg.max_hl;
    assign maxv[1] = cfg.max_lh;
    assign minv[0] = cfg.min_hl;
    assign minv[1] = cfg.min_lh;
    assign frz[0] = cfg.freeze_hl;
    assign frz[1] = cfg.freeze_lh;

    // Index 0 is the high-to-low edge, index 1 the low-to-high edge
    for (genvar e = 0; e < 2; e++) begin : g_edge
        ns_t lo;
        ns_t hi;
        ns_t prop;
        ns_t pick;
        // One register per edge, so each has a single driving process
        logic signed [7:0] eff_q;
        assign lo = ns_t'(minv[e]) * ns_t'(MIN_STEP_NS);
        assign hi = ns_t'(maxv[e]);
        assign prop = ns_t'(adapt[e]);
        // A floor above the ceiling is a host error; the floor wins so overlap never grows past it
        always_comb begin
            if (prop > hi) begin
                pick = hi;
            end else begin
                pick = prop;
            end
            if (pick < lo) begin
                pick = lo;
            end
        end
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                eff_q <= 8'sh00;
            end else if (frz[e]) begin
                eff_q <= stored[e];
            end else begin
                eff_q <= pick[7:0];
            end
        end
    end

    assign cfg.eff_hl = g_edge[0].eff_q;
    assign cfg.eff_lh = g_edge[1].eff_q;
endmodule : gap_select
`default_nettype wire

// File: core/gap_order_bank.sv
// Register bank: deadtime settings, adaptive limits, rail order links and calibration words
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - Temperature offset word stored, no functional effect
// - Read-only word returns strapped output ceiling
// - Eight-bit sense temperature correction factor stored
// - Upper byte: signed high-to-low deadtime ns
// - Lower byte: signed low-to-high deadtime ns
// - Positive means gap, negative means overlap
// - Adaptive high-to-low ceiling defaults to sixty
// - Gap write then config write sets maxima
// - Adaptive off: drive stored deadtime values
// - Bits 14:8 floor high-to-low at twice count
// - Bits 6:0 floor low-to-high at twice count
// - Bit 15 set freezes high-to-low deadtime
// - Bit 7 set freezes low-to-high deadtime
// - Bits 12:8 name predecessor rail identifier
// - Bits 4:0 name successor rail identifier
// - Bit 15 enables predecessor link
// - Bit 7 enables successor link
module gap_order_bank
    import gap_bank_pkg::*;
(
    input wire logic clock_in,
    input wire logic resetn_in,
    input wire logic [7:0] cmd_in,
    input wire logic wr_in,
    input wire logic [15:0] wdata_in,
    input wire logic rd_in,
    input wire logic [15:0] strap_vout_ceiling_in,
    input wire logic signed [7:0] adapt_hl_in,
    input wire logic signed [7:0] adapt_lh_in,
    output logic [15:0] rdata_out,
    output logic rd_valid_out,
    output logic cmd_err_out,
    output logic signed [7:0] gap_hl_out,
    output logic signed [7:0] gap_lh_out,
    output logic pre_en_out,
    output logic [4:0] pre_id_out,
    output logic post_en_out,
    output logic [4:0] post_id_out,
    output logic [7:0] sense_temp_correction_out
);
    logic rst_meta_q;
    logic rst_sync_q;
    logic rst_n;

    logic [15:0] ext_temp_cal_offset_q;
    logic [15:0] strapped_vout_ceiling_q;
    logic strap_taken_q;
    logic [7:0] sense_temp_correction_q;
    logic [15:0] switch_gap_values_q;
    logic [15:0] switch_gap_mode_limits_q;
    logic [15:0] rail_order_links_q;
    logic signed [7:0] max_hl_q;
    logic signed [7:0] max_lh_q;
    logic last_was_gap_q;

    logic [15:0] rdata_q;
    logic rd_valid_q;
    logic cmd_err_q;
    logic [15:0] read_mux;
    logic known_cmd;
    logic writable_cmd;

    gap_cfg_if cfg ();

    // Reset release through two flops
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end
    assign rst_n = rst_sync_q;

    always_comb begin
        known_cmd = 1'b1;
        writable_cmd = 1'b1;
        case (cmd_in)
            CMD_EXT_TEMP_CAL_OFFSET: writable_cmd = 1'b1;
            CMD_STRAPPED_VOUT_CEILING: writable_cmd = 1'b0;
            CMD_SENSE_TEMP_CORRECTION: writable_cmd = 1'b1;
            CMD_SWITCH_GAP_VALUES: writable_cmd = 1'b1;
            CMD_SWITCH_GAP_MODE_LIMITS: writable_cmd = 1'b1;
            CMD_RAIL_ORDER_LINKS: writable_cmd = 1'b1;
            default: begin
                known_cmd = 1'b0;
                writable_cmd = 1'b0;
            end
        endcase
    end

    // Strapped ceiling is caught once, on the first edge after reset release
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            strapped_vout_ceiling_q <= 16'h0000;
            strap_taken_q <= 1'b0;
        end else if (!strap_taken_q) begin
            strapped_vout_ceiling_q <= strap_vout_ceiling_in;
            strap_taken_q <= 1'b1;
        end
    end

    // Calibration words
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            ext_temp_cal_offset_q <= EXT_TEMP_CAL_OFFSET_RST;
            sense_temp_correction_q <= SENSE_TEMP_CORRECTION_RST;
        end else if (wr_in) begin
            if (cmd_in == CMD_EXT_TEMP_CAL_OFFSET) begin
                ext_temp_cal_offset_q <= wdata_in;
            end
            if (cmd_in == CMD_SENSE_TEMP_CORRECTION) begin
                sense_temp_correction_q <= wdata_in[7:0];
            end
        end
    end

    // Deadtime word; factory value is meant to stay, but writes are honoured
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            switch_gap_values_q <= SWITCH_GAP_VALUES_RST;
        end else if (wr_in && cmd_in == CMD_SWITCH_GAP_VALUES) begin
            switch_gap_values_q <= wdata_in;
        end
    end

    // Mode and floor word
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            switch_gap_mode_limits_q <= SWITCH_GAP_MODE_LIMITS_RST;
        end else if (wr_in && cmd_in == CMD_SWITCH_GAP_MODE_LIMITS) begin
            switch_gap_mode_limits_q <= wdata_in & MODE_LIMITS_MASK;
        end
    end

    // Any accepted command other than a deadtime write breaks the back-to-back pair
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            last_was_gap_q <= 1'b0;
        end else if (wr_in || rd_in) begin
            last_was_gap_q <= wr_in && cmd_in == CMD_SWITCH_GAP_VALUES;
        end
    end

    // Adaptive ceilings
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            max_hl_q <= GAP_MAX_RST_NS;
            max_lh_q <= GAP_MAX_RST_NS;
        end else if (wr_in && cmd_in == CMD_SWITCH_GAP_MODE_LIMITS && last_was_gap_q) begin
            max_hl_q <= switch_gap_values_q[GAP_HL_LSB +: GAP_W];
            max_lh_q <= switch_gap_values_q[GAP_LH_LSB +: GAP_W];
        end
    end

    // Rail order links
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            rail_order_links_q <= RAIL_ORDER_LINKS_RST;
        end else if (wr_in && cmd_in == CMD_RAIL_ORDER_LINKS) begin
            rail_order_links_q <= wdata_in & ORDER_LINKS_MASK;
        end
    end

    always_comb begin
        case (cmd_in)
            CMD_EXT_TEMP_CAL_OFFSET: read_mux = ext_temp_cal_offset_q;
            CMD_STRAPPED_VOUT_CEILING: read_mux = strapped_vout_ceiling_q;
            CMD_SENSE_TEMP_CORRECTION: read_mux = {8'h00, sense_temp_correction_q};
            CMD_SWITCH_GAP_VALUES: read_mux = switch_gap_values_q;
            CMD_SWITCH_GAP_MODE_LIMITS: read_mux = switch_gap_mode_limits_q;
            CMD_RAIL_ORDER_LINKS: read_mux = rail_order_links_q & ORDER_LINKS_MASK;
            default: read_mux = 16'h0000;
        endcase
    end

    // Read answer one cycle after the strobe; unknown command reads zero and flags an error
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 16'h0000;
            rd_valid_q <= 1'b0;
            cmd_err_q <= 1'b0;
        end else begin
            rd_valid_q <= rd_in && !wr_in;
            if (rd_in && !wr_in) begin
                rdata_q <= read_mux;
            end
            cmd_err_q <= (rd_in && !known_cmd) || (wr_in && !writable_cmd);
        end
    end

    assign cfg.gap_hl = switch_gap_values_q[GAP_HL_LSB +: GAP_W];
    assign cfg.gap_lh = switch_gap_values_q[GAP_LH_LSB +: GAP_W];
    assign cfg.max_hl = max_hl_q;
    assign cfg.max_lh = max_lh_q;
    assign cfg.min_hl = switch_gap_mode_limits_q[MIN_HL_LSB +: MIN_W];
    assign cfg.min_lh = switch_gap_mode_limits_q[MIN_LH_LSB +: MIN_W];
    assign cfg.freeze_hl = switch_gap_mode_limits_q[FREEZE_HL_BIT];
    assign cfg.freeze_lh = switch_gap_mode_limits_q[FREEZE_LH_BIT];

    // Effective deadtimes are registered in the selector; sign gives gap or overlap
    gap_select u_select (
        .clk(clock_in),
        .rst_n(rst_n),
        .adapt_hl_in(adapt_hl_in),
        .adapt_lh_in(adapt_lh_in),
        .cfg(cfg)
    );

    assign gap_hl_out = cfg.eff_hl;
    assign gap_lh_out = cfg.eff_lh;
    assign rdata_out = rdata_q;
    assign rd_valid_out = rd_valid_q;
    assign cmd_err_out = cmd_err_q;
    assign pre_en_out = rail_order_links_q[PRE_EN_BIT];
    assign pre_id_out = rail_order_links_q[PRE_ID_LSB +: ID_W];
    assign post_en_out = rail_order_links_q[POST_EN_BIT];
    assign post_id_out = rail_order_links_q[POST_ID_LSB +: ID_W];
    assign sense_temp_correction_out = sense_temp_correction_q;
endmodule : gap_order_bank
`default_nettype wire

// File: testbench/gap_order_bank_asserts.sv
// Checker: register port answers and deadtime output relations
`timescale 1ns/100ps
`default_nettype none
module gap_order_bank_asserts
    import gap_bank_pkg::*;
(
    input wire logic clock_in,
    input wire logic resetn_in,
    input wire logic [7:0] cmd_in,
    input wire logic wr_in,
    input wire logic [15:0] wdata_in,
    input wire logic rd_in,
    input wire logic [15:0] rdata_out,
    input wire logic rd_valid_out,
    input wire logic cmd_err_out,
    input wire logic signed [7:0] gap_hl_out,
    input wire logic pre_en_out,
    input wire logic [4:0] pre_id_out,
    input wire logic [7:0] sense_temp_correction_out
);
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!resetn_in);
    logic freeze_q;
    logic signed [7:0] gap_q;
    logic signed [6:0] min_q;
    logic rdx;
    // A write wins over a read in the same cycle
    assign rdx = rd_in && !wr_in;
    // Shadow of the high-to-low settings, taken on the same edge as the bank
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            freeze_q <= 1'b0;
            min_q <= '0;
            gap_q <= '0;
        end else if (wr_in && cmd_in == CMD_SWITCH_GAP_MODE_LIMITS) begin
            freeze_q <= wdata_in[15];
            min_q <= wdata_in[14:8];
        end else if (wr_in && cmd_in == CMD_SWITCH_GAP_VALUES) begin
            gap_q <= wdata_in[15:8];
        end
    end
    a_ceiling_read: assert property (rdx && cmd_in == CMD_STRAPPED_VOUT_CEILING |=> rd_valid_out && !cmd_err_out)
        else $error("ceiling read");
    a_ceiling_no_write: assert property (wr_in && cmd_in == CMD_STRAPPED_VOUT_CEILING |=> cmd_err_out)
        else $error("ceiling write");
    a_factor_write: assert property (wr_in && cmd_in == CMD_SENSE_TEMP_CORRECTION |=> sense_temp_correction_out == $past(wdata_in[7:0]))
        else $error("factor write");
    a_factor_upper: assert property (rdx && cmd_in == CMD_SENSE_TEMP_CORRECTION |=> rdata_out[15:8] == 8'h00)
        else $error("factor upper");
    a_pre_link: assert property (wr_in && cmd_in == CMD_RAIL_ORDER_LINKS |=> pre_en_out == $past(wdata_in[15]) && pre_id_out == $past(wdata_in[12:8]))
        else $error("pre link");
    a_order_spare: assert property (rdx && cmd_in == CMD_RAIL_ORDER_LINKS |=> rdata_out[14:13] == 2'h0 && rdata_out[6:5] == 2'h0)
        else $error("order spare");
    a_frozen_gap: assert property (freeze_q |=> gap_hl_out == $past(gap_q))
        else $error("frozen gap");
    a_floor_hl: assert property (!freeze_q |=> ns_t'(gap_hl_out) >= ns_t'($past(min_q)) * 2)
        else $error("floor hl");
    c_pairing: cover property (wr_in && cmd_in == CMD_SWITCH_GAP_VALUES ##2 wr_in && cmd_in == CMD_SWITCH_GAP_MODE_LIMITS);
    c_freeze: cover property (freeze_q ##1 freeze_q);
    c_refused: cover property (cmd_err_out);
endmodule : gap_order_bank_asserts
bind gap_order_bank gap_order_bank_asserts u_gap_order_bank_asserts (
    .clock_in(clock_in), .resetn_in(resetn_in), .cmd_in(cmd_in), .wr_in(wr_in), .wdata_in(wdata_in),
    .rd_in(rd_in), .rdata_out(rdata_out), .rd_valid_out(rd_valid_out), .cmd_err_out(cmd_err_out),
    .gap_hl_out(gap_hl_out), .pre_en_out(pre_en_out), .pre_id_out(pre_id_out),
    .sense_temp_correction_out(sense_temp_correction_out)
);
`default_nettype wire

// File: testbench/mgmt_host_model.sv
// Management bus host model: one-cycle write or read strobes and answer capture
`timescale 1ns/100ps
`default_nettype none
module mgmt_host_model (
    input wire logic clk_in,
    input wire logic [15:0] rdata_in,
    input wire logic rd_valid_in,
    input wire logic cmd_err_in,
    output logic [7:0] cmd_out,
    output logic wr_out,
    output logic rd_out,
    output logic [15:0] wdata_out
);
    initial begin
        cmd_out = 8'h00;
        wr_out = 1'b0;
        rd_out = 1'b0;
        wdata_out = 16'h0000;
    end
    // Deadtime words are only written when a caller asks for it
    // Idle data is inverted so a bank sampling it between requests stores garbage
    task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                        output logic [15:0] q, output logic v, output logic e);
        @(negedge clk_in);
        cmd_out = c;
        wr_out = w;
        rd_out = !w;
        wdata_out = w ? d : ~wdata_out;
        @(negedge clk_in);
        wr_out = 1'b0;
        rd_out = 1'b0;
        wdata_out = ~wdata_out;
        q = rdata_in;
        v = rd_valid_in;
        e = cmd_err_in;
    endtask : xfer
endmodule : mgmt_host_model
`default_nettype wire

// File: testbench/deadtime_and_rail_order_config_bank_tb_top.sv
// Testbench: reads, writes, clamps, freeze and maximum pairing of the bank
`timescale 1ns/100ps
`default_nettype none
module deadtime_and_rail_order_config_bank_tb_top;
    import gap_bank_pkg::*;
    localparam logic [15:0] STRAP = 16'h0266;
    logic clock_in, resetn_in, wr_in, rd_in, rd_valid_out, cmd_err_out, pre_en_out, post_en_out, v, e;
    logic [7:0] cmd_in, sense_temp_correction_out;
    logic [15:0] wdata_in, strap_vout_ceiling_in, rdata_out, q, links;
    logic signed [7:0] adapt_hl_in, adapt_lh_in, gap_hl_out, gap_lh_out;
    logic [4:0] pre_id_out, post_id_out;
    int mismatches = 0;
    int compares = 0;
    int cycles = 0;
    assign links = {pre_en_out, 2'h0, pre_id_out, post_en_out, 2'h0, post_id_out};
    gap_order_bank u_gap_order_bank (
        .clock_in(clock_in), .resetn_in(resetn_in), .cmd_in(cmd_in), .wr_in(wr_in), .wdata_in(wdata_in),
        .rd_in(rd_in), .strap_vout_ceiling_in(strap_vout_ceiling_in), .adapt_hl_in(adapt_hl_in),
        .adapt_lh_in(adapt_lh_in), .rdata_out(rdata_out), .rd_valid_out(rd_valid_out),
        .cmd_err_out(cmd_err_out), .gap_hl_out(gap_hl_out), .gap_lh_out(gap_lh_out),
        .pre_en_out(pre_en_out), .pre_id_out(pre_id_out), .post_en_out(post_en_out),
        .post_id_out(post_id_out), .sense_temp_correction_out(sense_temp_correction_out)
    );
    mgmt_host_model u_mgmt_host_model (
        .clk_in(clock_in), .rdata_in(rdata_out), .rd_valid_in(rd_valid_out), .cmd_err_in(cmd_err_out),
        .cmd_out(cmd_in), .wr_out(wr_in), .rd_out(rd_in), .wdata_out(wdata_in)
    );
    initial begin
        clock_in = 1'b0;
        forever #5 clock_in = ~clock_in;
    end
    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            finish_test();
        end
    end
    task automatic finish_test;
        if (mismatches == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : finish_test
    task automatic chk(input string n, input logic [15:0] x, input logic [15:0] g);
        compares++;
        if (g !== x) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", n, x, g);
        end
    endtask : chk
    task automatic wrq(input logic [7:0] c, input logic [15:0] d);
        u_mgmt_host_model.xfer(1'b1, c, d, q, v, e);
    endtask : wrq
    task automatic rdchk(input string n, input logic [7:0] c, input logic [15:0] x);
        u_mgmt_host_model.xfer(1'b0, c, 16'h0000, q, v, e);
        chk({n, " valid"}, 16'h0001, {15'h0000, v});
        chk(n, x, q);
    endtask : rdchk
    // Output is registered one cycle behind the stored settings
    task automatic gapchk(input logic signed [7:0] h, input logic signed [7:0] l);
        repeat (3) @(negedge clock_in);
        chk("gap_hl", {8'h00, h}, {8'h00, gap_hl_out});
        chk("gap_lh", {8'h00, l}, {8'h00, gap_lh_out});
    endtask : gapchk
    task automatic t_ceiling;
        rdchk("offset rst", CMD_EXT_TEMP_CAL_OFFSET, 16'h0000);
        rdchk("ceiling", CMD_STRAPPED_VOUT_CEILING, STRAP);
        wrq(CMD_STRAPPED_VOUT_CEILING, ~STRAP);
        chk("ro err", 16'h0001, {15'h0000, e});
        rdchk("ceiling kept", CMD_STRAPPED_VOUT_CEILING, STRAP);
        wrq(8'hDF, 16'h1234);
        chk("unknown wr err", 16'h0001, {15'h0000, e});
        rdchk("unknown rd", 8'hDF, 16'h0000);
        chk("unknown rd err", 16'h0001, {15'h0000, e});
    endtask : t_ceiling
    task automatic t_words;
        wrq(CMD_EXT_TEMP_CAL_OFFSET, 16'hA5C3);
        rdchk("offset", CMD_EXT_TEMP_CAL_OFFSET, 16'hA5C3);
        wrq(CMD_SENSE_TEMP_CORRECTION, 16'h12B7);
        rdchk("factor", CMD_SENSE_TEMP_CORRECTION, 16'h00B7);
        chk("factor out", 16'h00B7, {8'h00, sense_temp_correction_out});
        wrq(CMD_RAIL_ORDER_LINKS, 16'hFFFF);
        rdchk("order spare", CMD_RAIL_ORDER_LINKS, 16'h9F9F);
        wrq(CMD_RAIL_ORDER_LINKS, 16'h0A85);
        chk("links", 16'h0A85, links);
    endtask : t_words
    task automatic t_clamp;
        adapt_hl_in = 8'sd61;
        adapt_lh_in = 8'sd33;
        gapchk(8'sd60, 8'sd33);
        wrq(CMD_SWITCH_GAP_MODE_LIMITS, 16'h0A7B);
        rdchk("limits", CMD_SWITCH_GAP_MODE_LIMITS, 16'h0A7B);
        adapt_hl_in = 8'sd5;
        adapt_lh_in = -8'sd20;
        gapchk(8'sd20, -8'sd10);
    endtask : t_clamp
    task automatic t_freeze;
        wrq(CMD_SWITCH_GAP_VALUES, 16'h28F6);
        rdchk("gap word", CMD_SWITCH_GAP_VALUES, 16'h28F6);
        wrq(CMD_SWITCH_GAP_MODE_LIMITS, 16'h8080);
        adapt_hl_in = 8'sd7;
        adapt_lh_in = 8'sd0;
        gapchk(8'sd40, -8'sd10);
        wrq(CMD_SWITCH_GAP_MODE_LIMITS, 16'h8000);
        gapchk(8'sd40, 8'sd0);
    endtask : t_freeze
    task automatic t_new_max;
        wrq(CMD_SWITCH_GAP_VALUES, 16'h1E32);
        wrq(CMD_SWITCH_GAP_MODE_LIMITS, 16'h0000);
        adapt_hl_in = 8'sd55;
        adapt_lh_in = 8'sd58;
        gapchk(8'sd30, 8'sd50);
        wrq(CMD_SWITCH_GAP_VALUES, 16'h0A0A);
        rdchk("gap word 2", CMD_SWITCH_GAP_VALUES, 16'h0A0A);
        wrq(CMD_SWITCH_GAP_MODE_LIMITS, 16'h0000);
        gapchk(8'sd30, 8'sd50);
    endtask : t_new_max
    // Mid-run reset must bring back the default ceilings and cleared words
    task automatic t_reset;
        @(negedge clock_in);
        resetn_in = 1'b0;
        repeat (2) @(negedge clock_in);
        resetn_in = 1'b1;
        repeat (4) @(negedge clock_in);
        rdchk("offset rst 2", CMD_EXT_TEMP_CAL_OFFSET, 16'h0000);
        rdchk("ceiling rst 2", CMD_STRAPPED_VOUT_CEILING, STRAP);
        gapchk(8'sd55, 8'sd58);
    endtask : t_reset
    initial begin
        resetn_in = 1'b0;
        strap_vout_ceiling_in = STRAP;
        adapt_hl_in = 8'sd0;
        adapt_lh_in = 8'sd0;
        repeat (20) @(negedge clock_in);
        resetn_in = 1'b1;
        repeat (4) @(negedge clock_in);
        t_ceiling();
        t_words();
        t_clamp();
        t_freeze();
        t_new_max();
        t_reset();
        finish_test();
    end
endmodule : deadtime_and_rail_order_config_bank_tb_top
`default_nettype wire
